// File: rtl/ssw_pkg.sv
// Constants, register map and state types of the safety gate switch logic.
// Assumes a single 125 MHz system clock shared by every module of the block.
package ssw_pkg;

    localparam int CLK_NS = 8;

    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;

    // Register byte addresses
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_TEACH = 8'h08;
    localparam logic [7:0] OFF_SERIAL = 8'h0C;
    localparam logic [7:0] OFF_NAME = 8'h10;

    // Control register fields
    localparam int CTRL_DIAG_ALLOW_BIT = 0;
    localparam int CTRL_ADDR_LSB = 4;
    localparam logic CTRL_DIAG_ALLOW_RST = 1'b1;
    localparam logic [3:0] CTRL_ADDR_RST = 4'h0;

    // Status register fields
    localparam int ST_PRESENT_BIT = 0;
    localparam int ST_IN1_BIT = 1;
    localparam int ST_IN2_BIT = 2;
    localparam int ST_OUT1_BIT = 3;
    localparam int ST_OUT2_BIT = 4;
    localparam int ST_UNEQUAL_BIT = 5;
    localparam int ST_PLAUS_ERR_BIT = 6;
    localparam int ST_DIAG_MODE_BIT = 7;
    localparam int ST_TAUGHT_BIT = 8;
    localparam int ST_READY_BIT = 9;
    localparam int ST_WIDTH = 10;

    localparam logic [7:0] TEACH_INIT = 8'h01;
    localparam logic [1:0] STARTUP_CYC = 2'h3;

    // Timing
    localparam int FLASH_HALF_MS = 250;
    localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000000 / CLK_NS;
    localparam int DIAG_DETECT_US = 100;
    localparam int DIAG_DETECT_CYC = DIAG_DETECT_US * 1000 / CLK_NS;
    localparam int DIAG_BIT_NS = 8680;
    localparam logic [10:0] DIAG_BIT_CYC = 11'(DIAG_BIT_NS / CLK_NS);
    localparam logic [10:0] DIAG_HALF_CYC = 11'(DIAG_BIT_NS / CLK_NS / 2);

    // Diagnostics chain
    localparam int DIAG_SUBSCRIBERS = 16;
    localparam int DIAG_ADDR_W = $clog2(DIAG_SUBSCRIBERS);
    localparam logic [3:0] CMD_POLL = 4'h1;
    localparam logic [3:0] CMD_TEACH = 4'h2;
    localparam logic [3:0] CMD_SERIAL = 4'h3;
    localparam logic [3:0] CMD_NAME = 4'h4;
    localparam logic [4:0] DIAG_FRAME_BITS = 5'h1E;

    typedef enum logic [3:0] {
        PL_WAIT_LOW = 4'b0001,
        PL_NORMAL = 4'b0010,
        PL_UNEQUAL = 4'b0100,
        PL_LOCK = 4'b1000
    } ssw_plaus_e;

    typedef enum logic [3:0] {
        RX_IDLE = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA = 4'b0100,
        RX_STOP = 4'b1000
    } ssw_rx_e;

endpackage : ssw_pkg

// File: rtl/ssw_diag_if.sv
// Signals between the switch core and its diagnostics link engine.
// Assumes both ends sit on ref_clk.
`timescale 1ns/10ps
`default_nettype none
interface ssw_diag_if;
    logic diagMode;
    logic rxLine;
    logic [ssw_pkg::DIAG_ADDR_W-1:0] address;
    logic [7:0] statusByte;
    logic [7:0] teachLeft;
    logic [15:0] serialNo;
    logic [15:0] liveName;
    logic refreshReq;
    logic txLine;

    modport core (
        output diagMode,
        output rxLine,
        output address,
        output statusByte,
        output teachLeft,
        output serialNo,
        output liveName,
        input refreshReq,
        input txLine
    );

    modport link (
        input diagMode,
        input rxLine,
        input address,
        input statusByte,
        input teachLeft,
        input serialNo,
        input liveName,
        output refreshReq,
        output txLine
    );
endinterface : ssw_diag_if
`default_nettype wire

// File: rtl/ssw_sync.sv
// Two-flop synchroniser for a group of asynchronous level inputs.
// Assumes the levels are slow compared to ref_clk.
`timescale 1ns/10ps
`default_nettype none
module ssw_sync #(
    parameter int W = 4
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [W-1:0] async,
    output logic [W-1:0] synced
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ssw_sync_s;

    ssw_sync_s s_r;
    ssw_sync_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.meta = async;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign synced = s_r.stable;
endmodule : ssw_sync
`default_nettype wire

// File: rtl/ssw_diag.sv
// Diagnostics link engine: 8N1 serial, one command byte in, three bytes out.
// Assumes the line is already synchronised and idles high.
`timescale 1ns/10ps
`default_nettype none
module ssw_diag (
    input wire logic ref_clk,
    input wire logic reset,
    ssw_diag_if.link dl
);
    typedef struct packed {
        ssw_pkg::ssw_rx_e rx;
        logic [10:0] rxCnt;
        logic [2:0] rxIdx;
        logic [7:0] rxShift;
        logic [29:0] txShift;
        logic [4:0] txBits;
        logic [10:0] txCnt;
        logic txOut;
        logic refresh;
    } ssw_diag_s;

    localparam ssw_diag_s DIAG_RST = '{rx: ssw_pkg::RX_IDLE, rxCnt: 11'h000, rxIdx: 3'h0,
        rxShift: 8'h00, txShift: 30'h0, txBits: 5'h00, txCnt: 11'h000, txOut: 1'b1,
        refresh: 1'b0};

    ssw_diag_s s_r;
    ssw_diag_s s_nxt;

    always_comb begin
        logic [15:0] data;
        logic answer;
        data = 16'h0000;
        answer = 1'b0;
        s_nxt = s_r;
        s_nxt.refresh = 1'b0;
        if (!dl.diagMode) begin
            s_nxt = DIAG_RST;
        end else begin
            s_nxt.rxCnt = s_r.rxCnt + 11'h001;
            unique case (s_r.rx)
                ssw_pkg::RX_IDLE: begin
                    s_nxt.rxCnt = 11'h000;
                    if (!dl.rxLine) begin
                        s_nxt.rx = ssw_pkg::RX_START;
                    end
                end
                ssw_pkg::RX_START: begin
                    if (s_r.rxCnt == ssw_pkg::DIAG_HALF_CYC - 11'h001) begin
                        s_nxt.rxCnt = 11'h000;
                        s_nxt.rxIdx = 3'h0;
                        s_nxt.rx = dl.rxLine ? ssw_pkg::RX_IDLE : ssw_pkg::RX_DATA;
                    end
                end
                ssw_pkg::RX_DATA: begin
                    if (s_r.rxCnt == ssw_pkg::DIAG_BIT_CYC - 11'h001) begin
                        s_nxt.rxCnt = 11'h000;
                        s_nxt.rxShift = {dl.rxLine, s_r.rxShift[7:1]};
                        s_nxt.rxIdx = s_r.rxIdx + 3'h1;
                        if (s_r.rxIdx == 3'h7) begin
                            s_nxt.rx = ssw_pkg::RX_STOP;
                        end
                    end
                end
                ssw_pkg::RX_STOP: begin
                    if (s_r.rxCnt == ssw_pkg::DIAG_BIT_CYC - 11'h001) begin
                        s_nxt.rx = ssw_pkg::RX_IDLE;
                        // Bad stop bit, other subscriber or answer in flight: drop
                        if (dl.rxLine && s_r.rxShift[7:4] == dl.address
                                && s_r.txBits == 5'h00) begin
                            answer = 1'b1;
                            unique case (s_r.rxShift[3:0])
                                ssw_pkg::CMD_POLL: data = {8'h00, dl.statusByte};
                                ssw_pkg::CMD_TEACH: data = {8'h00, dl.teachLeft};
                                ssw_pkg::CMD_SERIAL: data = dl.serialNo;
                                ssw_pkg::CMD_NAME: begin
                                    data = dl.liveName;
                                    s_nxt.refresh = 1'b1;
                                end
                                default: answer = 1'b0;
                            endcase
                        end
                    end
                end
            endcase
            if (s_r.txBits != 5'h00) begin
                s_nxt.txCnt = s_r.txCnt + 11'h001;
                if (s_r.txCnt == ssw_pkg::DIAG_BIT_CYC - 11'h001) begin
                    s_nxt.txCnt = 11'h000;
                    s_nxt.txShift = {1'b1, s_r.txShift[29:1]};
                    s_nxt.txBits = s_r.txBits - 5'h01;
                end
            end else if (answer) begin
                s_nxt.txCnt = 11'h000;
                s_nxt.txBits = ssw_pkg::DIAG_FRAME_BITS;
                s_nxt.txShift = {1'b1, data[7:0], 1'b0, 1'b1, data[15:8], 1'b0,
                    1'b1, s_r.rxShift, 1'b0};
            end
            s_nxt.txOut = (s_nxt.txBits != 5'h00) ? s_nxt.txShift[0] : 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_r <= DIAG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dl.txLine = s_r.txOut;
    assign dl.refreshReq = s_r.refresh;
endmodule : ssw_diag
`default_nettype wire

// File: rtl/ssw_top.sv
// Output, plausibility, teach-in and diagnostics control of a dual-channel
// safety gate switch. Assumes the transponder front end gives a presence level
// and a stable actuator code while present; all pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Present actuator: each output follows its input
// - No actuator: outputs low, signal low outside diagnostics mode
// - Outputs off whenever safe operation unsure
// - Mapping only while ready, green indicator
// - One input falls: unequal flag, yellow flash
// - Fallen input returns: plausibility error, lock
// - Both inputs low before rising accepted
// - Module present: diagnostic input enabled automatically
// - No module: diagnostic input ignored
// - Diagnostics mode: signal output transmits
// - Up to sixteen chained subscribers addressed
// - Link re-established after every power-up
// - Poll returns sensor status
// - Teach count and serial number readable
// - Action refreshes and returns actuator name
// - Teach first actuator only, refuse others
module ssw_top #(
    parameter logic [15:0] SERIAL_NUMBER = 16'h1234, // Arbitrary value
    parameter int FLASH_HALF_CYC = ssw_pkg::FLASH_HALF_CYC,
    parameter int DIAG_DETECT_CYC = ssw_pkg::DIAG_DETECT_CYC
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic safety_in_ch1,
    input wire logic safety_in_ch2,
    input wire logic actuatorPresent,
    input wire logic [15:0] actuatorCode,
    input wire logic diag_in,
    output logic safety_out_ch1,
    output logic safety_out_ch2,
    output logic signal_diag_out,
    output logic powerLedGreen,
    output logic inputLedYellow,
    input wire logic [ssw_pkg::REG_ADDR_W-1:0] regAddr,
    input wire logic [ssw_pkg::REG_DATA_W-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [ssw_pkg::REG_DATA_W-1:0] regRdata
);
    typedef struct packed {
        ssw_pkg::ssw_plaus_e plaus;
        logic failedCh2;
        logic prevIn1;
        logic prevIn2;
        logic unequal;
        logic plausErr;
        logic [1:0] startCnt;
        logic ready;
        logic taught;
        logic [15:0] taughtCode;
        logic [7:0] teachLeft;
        logic [15:0] nameCode;
        logic detDone;
        logic diagMode;
        logic [31:0] detCnt;
        logic [31:0] flashCnt;
        logic flashPhase;
        logic diagAllow;
        logic [ssw_pkg::DIAG_ADDR_W-1:0] address;
        logic out1;
        logic out2;
        logic sigOut;
        logic ledYellow;
        logic [ssw_pkg::REG_DATA_W-1:0] rdata;
    } ssw_core_s;

    localparam ssw_core_s CORE_RST = '{plaus: ssw_pkg::PL_WAIT_LOW, failedCh2: 1'b0,
        prevIn1: 1'b0, prevIn2: 1'b0, unequal: 1'b0, plausErr: 1'b0, startCnt: 2'h0,
        ready: 1'b0, taught: 1'b0, taughtCode: 16'h0000, teachLeft: ssw_pkg::TEACH_INIT,
        nameCode: 16'h0000, detDone: 1'b0, diagMode: 1'b0, detCnt: 32'h00000000,
        flashCnt: 32'h00000000, flashPhase: 1'b0,
        diagAllow: ssw_pkg::CTRL_DIAG_ALLOW_RST, address: ssw_pkg::CTRL_ADDR_RST,
        out1: 1'b0, out2: 1'b0, sigOut: 1'b0, ledYellow: 1'b0, rdata: 32'h00000000};

    ssw_core_s s_r;
    ssw_core_s s_nxt;

    logic [3:0] pinSync;
    logic in1;
    logic in2;
    logic present;
    logic diagLine;
    logic detected;
    logic [ssw_pkg::ST_WIDTH-1:0] status;

    ssw_diag_if dif ();

    ssw_sync #(
        .W(4)
    ) u_sync (
        .ref_clk(ref_clk),
        .reset(reset),
        .async({diag_in, actuatorPresent, safety_in_ch2, safety_in_ch1}),
        .synced(pinSync)
    );

    assign in1 = pinSync[0];
    assign in2 = pinSync[1];
    assign present = pinSync[2];
    assign diagLine = pinSync[3];

    // Only the taught actuator counts once teach-in is used up
    assign detected = present && (!s_r.taught || actuatorCode == s_r.taughtCode);

    always_comb begin
        status = '0;
        status[ssw_pkg::ST_PRESENT_BIT] = detected;
        status[ssw_pkg::ST_IN1_BIT] = in1;
        status[ssw_pkg::ST_IN2_BIT] = in2;
        status[ssw_pkg::ST_OUT1_BIT] = s_r.out1;
        status[ssw_pkg::ST_OUT2_BIT] = s_r.out2;
        status[ssw_pkg::ST_UNEQUAL_BIT] = s_r.unequal;
        status[ssw_pkg::ST_PLAUS_ERR_BIT] = s_r.plausErr;
        status[ssw_pkg::ST_DIAG_MODE_BIT] = s_r.diagMode;
        status[ssw_pkg::ST_TAUGHT_BIT] = s_r.taught;
        status[ssw_pkg::ST_READY_BIT] = s_r.ready;
    end

    assign dif.diagMode = s_r.diagMode;
    assign dif.rxLine = diagLine;
    assign dif.address = s_r.address;
    assign dif.statusByte = status[7:0];
    assign dif.teachLeft = s_r.teachLeft;
    assign dif.serialNo = SERIAL_NUMBER;
    assign dif.liveName = detected ? actuatorCode : 16'h0000;

    ssw_diag u_diag (
        .ref_clk(ref_clk),
        .reset(reset),
        .dl(dif.link)
    );

    always_comb begin
        logic fell1;
        logic fell2;
        logic rose1;
        logic rose2;
        logic pass;
        fell1 = s_r.prevIn1 && !in1;
        fell2 = s_r.prevIn2 && !in2;
        rose1 = !s_r.prevIn1 && in1;
        rose2 = !s_r.prevIn2 && in2;
        pass = 1'b0;
        s_nxt = s_r;
        s_nxt.prevIn1 = in1;
        s_nxt.prevIn2 = in2;

        // Short settle so the synchroniser holds real pin levels first
        if (s_r.startCnt != ssw_pkg::STARTUP_CYC) begin
            s_nxt.startCnt = s_r.startCnt + 2'h1;
        end
        s_nxt.ready = (s_r.startCnt == ssw_pkg::STARTUP_CYC);

        // Teach-in of the first actuator seen
        if (s_r.ready && present && !s_r.taught && s_r.teachLeft != 8'h00) begin
            s_nxt.taught = 1'b1;
            s_nxt.taughtCode = actuatorCode;
            s_nxt.teachLeft = s_r.teachLeft - 8'h01;
        end

        // Plausibility watch on the two inputs
        unique case (s_r.plaus)
            ssw_pkg::PL_WAIT_LOW: begin
                if (!in1 && !in2) begin
                    s_nxt.plaus = ssw_pkg::PL_NORMAL;
                end
            end
            ssw_pkg::PL_NORMAL: begin
                pass = 1'b1;
                if (fell1 && in2) begin
                    s_nxt.plaus = ssw_pkg::PL_UNEQUAL;
                    s_nxt.failedCh2 = 1'b0;
                end else if (fell2 && in1) begin
                    s_nxt.plaus = ssw_pkg::PL_UNEQUAL;
                    s_nxt.failedCh2 = 1'b1;
                end
            end
            ssw_pkg::PL_UNEQUAL: begin
                pass = 1'b1;
                if (!in1 && !in2) begin
                    s_nxt.plaus = ssw_pkg::PL_NORMAL;
                end else if ((s_r.failedCh2 ? rose2 && in1 : rose1 && in2)) begin
                    s_nxt.plaus = ssw_pkg::PL_LOCK;
                    pass = 1'b0;
                end
            end
            ssw_pkg::PL_LOCK: begin
                if (!in1 && !in2) begin
                    s_nxt.plaus = ssw_pkg::PL_NORMAL;
                end
            end
            default: s_nxt.plaus = ssw_pkg::PL_WAIT_LOW;
        endcase
        s_nxt.unequal = (s_nxt.plaus == ssw_pkg::PL_UNEQUAL);
        s_nxt.plausErr = (s_nxt.plaus == ssw_pkg::PL_LOCK);

        // Off is the safe state: anything uncertain drops both channels
        if (s_r.ready && detected && pass) begin
            s_nxt.out1 = in1;
            s_nxt.out2 = in2;
        end else begin
            s_nxt.out1 = 1'b0;
            s_nxt.out2 = 1'b0;
        end

        // Fieldbus module sensing, redone after every reset
        if (!s_r.detDone && s_r.ready) begin
            if (!s_r.diagAllow || !diagLine) begin
                s_nxt.detDone = 1'b1;
            end else if (s_r.detCnt == 32'(DIAG_DETECT_CYC - 1)) begin
                s_nxt.detDone = 1'b1;
                s_nxt.diagMode = 1'b1;
            end else begin
                s_nxt.detCnt = s_r.detCnt + 32'h00000001;
            end
        end
        if (!s_r.diagAllow) begin
            s_nxt.diagMode = 1'b0;
        end

        if (s_r.diagMode) begin
            s_nxt.sigOut = dif.txLine;
        end else begin
            s_nxt.sigOut = s_r.ready && detected;
        end

        if (dif.refreshReq) begin
            s_nxt.nameCode = detected ? actuatorCode : 16'h0000;
        end

        // Indicator flash rate divider
        if (s_r.flashCnt == 32'(FLASH_HALF_CYC - 1)) begin
            s_nxt.flashCnt = 32'h00000000;
            s_nxt.flashPhase = !s_r.flashPhase;
        end else begin
            s_nxt.flashCnt = s_r.flashCnt + 32'h00000001;
        end
        s_nxt.ledYellow = (s_r.unequal || s_r.plausErr) && s_r.flashPhase;

        // Register port
        if (regWrite && regAddr == ssw_pkg::OFF_CTRL) begin
            s_nxt.diagAllow = regWdata[ssw_pkg::CTRL_DIAG_ALLOW_BIT];
            s_nxt.address = regWdata[ssw_pkg::CTRL_ADDR_LSB +: ssw_pkg::DIAG_ADDR_W];
        end
        s_nxt.rdata = 32'h00000000;
        if (regRead) begin
            unique case (regAddr)
                ssw_pkg::OFF_CTRL: begin
                    s_nxt.rdata[ssw_pkg::CTRL_DIAG_ALLOW_BIT] = s_r.diagAllow;
                    s_nxt.rdata[ssw_pkg::CTRL_ADDR_LSB +: ssw_pkg::DIAG_ADDR_W] = s_r.address;
                end
                ssw_pkg::OFF_STATUS: s_nxt.rdata[ssw_pkg::ST_WIDTH-1:0] = status;
                ssw_pkg::OFF_TEACH: s_nxt.rdata[7:0] = s_r.teachLeft;
                ssw_pkg::OFF_SERIAL: s_nxt.rdata[15:0] = SERIAL_NUMBER;
                ssw_pkg::OFF_NAME: s_nxt.rdata[15:0] = s_r.nameCode;
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            s_r <= CORE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign safety_out_ch1 = s_r.out1;
    assign safety_out_ch2 = s_r.out2;
    assign signal_diag_out = s_r.sigOut;
    assign powerLedGreen = s_r.ready;
    assign inputLedYellow = s_r.ledYellow;
    assign regRdata = s_r.rdata;
endmodule : ssw_top
`default_nettype wire

// File: verif/ssw_top_props.sv
// Checker on the switch top ports.
// Assumes pins change right after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module ssw_top_props #(
    parameter logic [15:0] SERIAL_NUMBER = 16'h0001
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic safety_in_ch1,
    input wire logic safety_in_ch2,
    input wire logic actuatorPresent,
    input wire logic safety_out_ch1,
    input wire logic safety_out_ch2,
    input wire logic powerLedGreen,
    input wire logic [7:0] regAddr,
    input wire logic regRead,
    input wire logic [31:0] regRdata
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_split;
        safety_in_ch1 && safety_in_ch2 && safety_out_ch2 ##1 !safety_in_ch1 && safety_in_ch2;
    endsequence
    sequence s_rejoin;
        (!safety_in_ch1 && safety_in_ch2) [*3] ##1 safety_in_ch1 && safety_in_ch2;
    endsequence
    a_lock_on_rejoin: assert property (
        s_split ##1 s_rejoin |-> ##4 (!safety_out_ch1 && !safety_out_ch2) [*4])
        else $error("outputs not locked after rejoin");
    a_absent_off: assert property (
        !actuatorPresent [*3] |=> !safety_out_ch1 && !safety_out_ch2)
        else $error("output high without actuator");
    a_ch1_follows: assert property (safety_out_ch1 |-> $past(safety_in_ch1, 3))
        else $error("channel one output without its input");
    a_ch2_follows: assert property (safety_out_ch2 |-> $past(safety_in_ch2, 3))
        else $error("channel two output without its input");
    a_ready_rise: assert property ($fell(reset) |-> !powerLedGreen ##[1:5] powerLedGreen)
        else $error("ready indicator timing wrong");
    a_ready_holds: assert property (powerLedGreen |=> powerLedGreen)
        else $error("ready indicator dropped");
    a_read_idle: assert property (!regRead |=> regRdata == 32'h0)
        else $error("read data outside read slot");
    a_read_serial: assert property (
        regRead && regAddr == ssw_pkg::OFF_SERIAL |=> regRdata == {16'h0, SERIAL_NUMBER})
        else $error("serial number read wrong");
endmodule : ssw_top_props
`default_nettype wire

// File: verif/ssw_far_end.sv
// Far side: evaluation device on the outputs, fieldbus module on the diag line.
// Assumes it shares ref_clk with the switch.
`timescale 1ns/10ps
`default_nettype none
module ssw_far_end (
    input wire logic ref_clk,
    input wire logic attached,
    input wire logic txLine,
    input wire logic chan1,
    input wire logic chan2,
    output var logic diagLine,
    output var logic gateClosed
);
    logic sending = 1'b0;
    initial diagLine = 1'b0;
    // Detached line has no pull-up, so it wanders
    always @(posedge ref_clk) begin
        if (!attached) diagLine <= ~diagLine;
        else if (!sending) diagLine <= 1'b1;
    end
    always @(posedge ref_clk) gateClosed <= chan1 && chan2;
    task send_cmd(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        sending = 1'b1;
        for (int i = 0; i < 10; i++) begin
            diagLine <= f[i];
            repeat (ssw_pkg::DIAG_BIT_CYC) @(posedge ref_clk);
        end
        sending = 1'b0;
    endtask : send_cmd
    task get_reply(output logic [23:0] r);
        int n;
        r = 24'hXXXXXX;
        for (int k = 2; k >= 0; k--) begin
            for (n = 0; n < 20000 && txLine !== 1'b0; n++) @(posedge ref_clk);
            repeat (ssw_pkg::DIAG_HALF_CYC) @(posedge ref_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (ssw_pkg::DIAG_BIT_CYC) @(posedge ref_clk);
                r[k*8+i] = txLine;
            end
            repeat (ssw_pkg::DIAG_BIT_CYC) @(posedge ref_clk);
        end
    endtask : get_reply
endmodule : ssw_far_end
`default_nettype wire

// File: verif/test_ssw_top.sv
// Self-checking bench for the switch top.
// Assumes the far-side model and checker files are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_ssw_top;
    localparam logic [15:0] SN = 16'h5A3C; // Arbitrary value
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic in1 = 1'b0, in2 = 1'b0, present = 1'b1, attached = 1'b0;
    logic [15:0] code = 16'h2C61;
    logic out1, out2, sig, green, yellow, diagLine, regWrite = 1'b0, regRead = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0, regRdata, rd;
    logic [23:0] reply;
    int failures = 0, samples_checked = 0;
    always #4 ref_clk = ~ref_clk;
    ssw_top #(.SERIAL_NUMBER(SN), .FLASH_HALF_CYC(8), .DIAG_DETECT_CYC(16)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .safety_in_ch1(in1), .safety_in_ch2(in2),
        .actuatorPresent(present), .actuatorCode(code), .diag_in(diagLine),
        .safety_out_ch1(out1), .safety_out_ch2(out2), .signal_diag_out(sig),
        .powerLedGreen(green), .inputLedYellow(yellow), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    ssw_far_end i_host (.ref_clk(ref_clk), .attached(attached), .txLine(sig),
        .chan1(out1), .chan2(out2), .diagLine(diagLine), .gateClosed());
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
    endtask : reg_write
    task reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : reg_read
    task step(input logic a, input logic b, input int n, input logic e1, input logic e2);
        @(posedge ref_clk);
        in1 <= a;
        in2 <= b;
        repeat (n) @(posedge ref_clk);
        #1 check("outputs", {e1, e2}, {out1, out2});
    endtask : step
    task report_and_stop;
        $display("checked %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (95000) @(posedge ref_clk);
        failures++;
        report_and_stop();
    end
    initial begin
        logic [1:0] combos [5] = '{2'b01, 2'b00, 2'b10, 2'b00, 2'b11};
        logic sawHi, sawLo;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (30) @(posedge ref_clk);
        foreach (combos[i]) step(combos[i][1], combos[i][0], 6, combos[i][1], combos[i][0]);
        #1 check("signal", 1, sig);
        check("ready", 1, green);
        reg_read(ssw_pkg::OFF_STATUS, rd); check("status", 32'h31F, rd);
        reg_read(ssw_pkg::OFF_TEACH, rd); check("teachLeft", 0, rd);
        reg_read(ssw_pkg::OFF_SERIAL, rd); check("serial", {16'h0, SN}, rd);
        reg_read(8'h20, rd); check("unmapped", 0, rd);
        reg_write(ssw_pkg::OFF_CTRL, 32'h1);
        reg_read(ssw_pkg::OFF_CTRL, rd); check("ctrl", 1, rd);
        step(0, 1, 3, 0, 1);
        step(1, 1, 6, 0, 0);
        step(0, 0, 6, 0, 0);
        step(1, 1, 6, 1, 1);
        step(0, 1, 6, 0, 1);
        reg_read(ssw_pkg::OFF_STATUS, rd); check("unequal", 32'h335, rd);
        sawHi = 1'b0;
        sawLo = 1'b0;
        repeat (20) begin
            @(posedge ref_clk);
            sawHi |= (yellow === 1'b1);
            sawLo |= (yellow === 1'b0);
        end
        check("yellowFlash", 1, sawHi & sawLo);
        step(0, 0, 6, 0, 0);
        @(posedge ref_clk);
        present <= 1'b0;
        step(1, 1, 6, 0, 0);
        check("signal", 0, sig);
        @(posedge ref_clk);
        code <= 16'h7E05;
        present <= 1'b1;
        step(1, 1, 6, 0, 0);
        @(posedge ref_clk);
        code <= 16'h2C61;
        step(1, 1, 6, 1, 1);
        @(posedge ref_clk);
        attached <= 1'b1;
        reset <= 1'b1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (60) @(posedge ref_clk);
        reg_read(ssw_pkg::OFF_STATUS, rd); check("diagMode", 1, rd[7]);
        fork
            i_host.send_cmd({4'h0, ssw_pkg::CMD_SERIAL});
            i_host.get_reply(reply);
        join
        check("reply", {8'h03, SN}, reply);
        // Name action: echo, live actuator name, and the stored copy
        fork
            i_host.send_cmd({4'h0, ssw_pkg::CMD_NAME});
            i_host.get_reply(reply);
        join
        check("name", {8'h04, 16'h2C61}, reply);
        reg_read(ssw_pkg::OFF_NAME, rd); check("nameReg", {16'h0, 16'h2C61}, rd);
        report_and_stop();
    end
endmodule : test_ssw_top
bind ssw_top ssw_top_props #(.SERIAL_NUMBER(SERIAL_NUMBER)) i_props (
    .ref_clk(ref_clk), .reset(reset), .safety_in_ch1(safety_in_ch1),
    .safety_in_ch2(safety_in_ch2), .actuatorPresent(actuatorPresent),
    .safety_out_ch1(safety_out_ch1), .safety_out_ch2(safety_out_ch2),
    .powerLedGreen(powerLedGreen), .regAddr(regAddr), .regRead(regRead),
    .regRdata(regRdata));
`default_nettype wire
